// file: gauge_params.svh
// Constants of the gauge control subcommand unit: codes, bit positions, resets and timing.
`ifndef GAUGE_PARAMS_SVH
`define GAUGE_PARAMS_SVH

// ----------------------------------------
// Subcommand codes, control location and status word layout
// ----------------------------------------
`define SUB_STATUS          16'h0000
`define SUB_PART_CODE       16'h0001
`define SUB_FW_REV          16'h0002
`define SUB_CONFIG_CODE     16'h0004
`define SUB_LAST_CMD        16'h0007
`define SUB_CHEM_PROFILE    16'h0008
`define SUB_CELL_INSERTED   16'h000C
`define SUB_CELL_REMOVED    16'h000D
`define SUB_ENTER_EDIT      16'h0013
`define SUB_SMOOTH_ALIGN    16'h0019
`define SUB_POWERDOWN_ARM   16'h001B
`define SUB_POWERDOWN       16'h001C
`define SUB_PARTIAL_RESTART 16'h0042
`define LAST_CMD_LIMIT      16'h0015
`define CONTROL_LOC_LO      8'h00
`define CONTROL_LOC_HI      8'h01
`define ST_ARMED            15
`define ST_WATCHDOG         14
`define ST_LOCKED           13
`define ST_CALIBRATING      12
`define ST_AUTOCAL          11
`define ST_BOARD_CAL        10
`define ST_CAP_LEARNED      9
`define ST_RES_LEARNED      8
`define ST_INIT_DONE        7
`define ST_SLEEP            4
`define ST_CP_MODEL         3
`define ST_RT_FROZEN        2
`define ST_VOLT_GOOD        1
`define ST_CHEM_SWAPPED     0

// ----------------------------------------
// Reset values and timing
// ----------------------------------------
`define RST_CP_MODEL        1'b1
`define RST_RESULT          16'h0000
`define RST_LAST_CMD        16'h0000
`define CLK_HZ              64'd250000000
`define AUTOCAL_FIRST_S     64'd225
`define AUTOCAL_FIRST_CYC   (`AUTOCAL_FIRST_S * `CLK_HZ)
`define WAKE_HOLD_US        64'd200
`define WAKE_HOLD_CYC       ((`WAKE_HOLD_US * `CLK_HZ + 64'd999999) / 64'd1000000)

`endif

// file: gauge_pkg.sv
// Types shared by the gauge control subcommand unit and its wake detector.
package gauge_pkg;

    typedef enum logic [0:0] {
        PWR_RUN,
        PWR_DOWN
    } power_e;

    typedef struct packed {
        logic        cmd_valid;
        logic [15:0] cmd_code;
    } subcmd_s;

    typedef struct packed {
        logic        watchdog_restart_seen;
        logic        locked_access_state;
        logic        calibrating;
        logic        counter_autocal_active;
        logic        board_cal_active;
        logic        init_done;
        logic        sleep;
        logic        constant_power_model;
        logic        resistance_table_frozen;
        logic        cell_voltage_good;
    } core_status_s;

    typedef struct packed {
        logic        capacity_learn;
        logic        resistance_learn;
        logic        chemistry_swap;
        logic        chemistry_updated;
        logic        autocal_done;
    } core_event_s;

    typedef struct packed {
        logic [1:0]  pin_sync;
        logic        armed_low;
        logic [31:0] high_cnt;
        logic        wake;
    } wake_state_s;

    typedef struct packed {
        power_e      power;
        logic [15:0] result;
        logic        result_valid;
        logic [15:0] last_cmd;
        logic [15:0] status;
        logic        armed;
        logic        cap_learned;
        logic        res_learned;
        logic        cp_model;
        logic        chem_swapped;
        logic        cell_present;
        logic        param_edit;
        logic        autocal_run;
        logic        autocal_armed;
        logic [39:0] autocal_cnt;
        logic [1:0]  pin_sync;
        logic        pin_prev;
        logic        gauge_start;
        logic        smooth_align;
        logic        partial_restart;
        logic        autocal_start;
    } ctl_state_s;

endpackage : gauge_pkg

// file: gauge_wake_detect.sv
// Wake detector: low-to-high on the general output pin held high for a minimum time.
`timescale 1ns/100ps
`include "gauge_params.svh"

module gauge_wake_detect #(
    parameter int unsigned WAKE_HOLD_CYCLES = 32'(`WAKE_HOLD_CYC)
) (
    // Clock and reset
    input  wire logic sys_clk_in,
    input  wire logic rstn_in,
    // Control
    input  wire logic powered_down_in,
    input  wire logic general_output_pin_in,
    // Result
    output logic      wake_out
);
    import gauge_pkg::*;

    if (WAKE_HOLD_CYCLES < 1) begin : g_bad_hold
        $error("WAKE_HOLD_CYCLES must be at least one");
    end

    wake_state_s st_q;
    wake_state_s st_d;

    // ----------------------------------------------------------------
    // A low level must be seen first, then the high must last the whole hold time.
    // ----------------------------------------------------------------
    always_comb begin
        st_d          = st_q;
        st_d.pin_sync = {st_q.pin_sync[0], general_output_pin_in};
        st_d.wake     = 1'b0;
        if (!powered_down_in) begin
            st_d.armed_low = 1'b0;
            st_d.high_cnt  = 32'h0000_0000;
        end else if (!st_q.pin_sync[1]) begin
            st_d.armed_low = 1'b1;
            st_d.high_cnt  = 32'h0000_0000;
        end else if (st_q.armed_low) begin
            st_d.high_cnt = st_q.high_cnt + 32'h0000_0001;
            if (st_d.high_cnt >= WAKE_HOLD_CYCLES) begin // R26
                st_d.wake      = 1'b1;
                st_d.armed_low = 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign wake_out = st_q.wake;

endmodule : gauge_wake_detect

// file: gauge_control_subcommand_unit.sv
// Control subcommand interpreter with the read-only control status word.
`timescale 1ns/100ps
`include "gauge_params.svh"

// Overview of operation
// [R1] Host follows control write with two-byte subcommand
// [R2] Locked state blocks restricted subcommands
// [R3] Code 0x0000 returns the status word
// [R4] Status word read-only, set by conditions/subcommands
// [R5] Arm command sets armed bit 15
// [R6] Report watchdog, locked, calibrating, board-cal bits
// [R7] Autocal bit high while running, first 225s
// [R8] Capacity-learned bit cleared by reset, cell-present
// [R9] Resistance bit only after capacity learned
// [R10] Report init, sleep, frozen, voltage-good; reserved zero
// [R11] Constant-power model bit resets to one
// [R12] Chemistry-swapped set on swap, cleared on update
// [R13] Code 0x0001 returns fixed part code
// [R14] Code 0x0002 returns firmware revision
// [R15] Code 0x0004 returns config code low byte
// [R16] Code 0x0007 returns last command, below 0x15
// [R17] Code 0x0008 returns chemistry profile identifier
// [R18] Insert command sets cell-present when pin-detect off
// [R19] Remove command clears cell-present when pin-detect off
// [R20] Enter-edit command sets edit flag when unlocked
// [R21] Host waits 1100ms before editing parameters
// [R22] Partial restart leaves edit mode, gauging resumes
// [R23] Align command copies true values to smoothed
// [R24] Power-down command powers down immediately
// [R25] Power-down only works after arming
// [R26] Wake needs pin high at least 200us
// [R27] Reserved bits zero; unknown codes change nothing
module gauge_control_subcommand_unit #(
    parameter logic [15:0] PART_CODE           = 16'hA5C3, // Arbitrary value.
    parameter logic [15:0] FIRMWARE_REVISION   = 16'h0100,
    parameter logic [7:0]  CONFIG_CODE         = 8'h00,
    parameter logic [15:0] CHEMISTRY_PROFILE   = 16'h0000,
    parameter logic [39:0] AUTOCAL_FIRST_CYCLES = 40'(`AUTOCAL_FIRST_CYC),
    parameter int unsigned WAKE_HOLD_CYCLES     = 32'(`WAKE_HOLD_CYC)
) (
    // Clock and reset
    input  wire logic                  sys_clk_in,
    input  wire logic                  rstn_in,
    // Control location write and read
    input  wire gauge_pkg::subcmd_s    subcmd_in,
    output logic [15:0]                control_result_out,
    output logic                       control_result_valid_out,
    output logic [15:0]                control_status_word_out,
    // Conditions and events from the gauge core
    input  wire gauge_pkg::core_status_s core_status_in,
    input  wire gauge_pkg::core_event_s  core_event_in,
    input  wire logic                  pin_detect_enable_in,
    // Pins
    input  wire logic                  cell_detect_pin_in,
    input  wire logic                  general_output_pin_in,
    // Actions toward the gauge core
    output logic                       cell_present_out,
    output logic                       gauging_start_out,
    output logic                       param_edit_flag_out,
    output logic                       partial_restart_out,
    output logic                       smoothing_align_out,
    output logic                       autocal_start_out,
    output logic                       powerdown_out
);
    import gauge_pkg::*;

    // ----------------------------------------
    // Elaboration checks
    // ----------------------------------------
    if (AUTOCAL_FIRST_CYCLES == 40'h00_0000_0000) begin : g_bad_autocal
        $error("AUTOCAL_FIRST_CYCLES must be at least one");
    end

    // ----------------------------------------
    // Decoding helpers
    // ----------------------------------------
    function automatic logic code_known(input logic [15:0] code);
        case (code)
            `SUB_STATUS, `SUB_PART_CODE, `SUB_FW_REV, `SUB_CONFIG_CODE,
            `SUB_LAST_CMD, `SUB_CHEM_PROFILE, `SUB_CELL_INSERTED,
            `SUB_CELL_REMOVED, `SUB_ENTER_EDIT, `SUB_SMOOTH_ALIGN,
            `SUB_POWERDOWN_ARM, `SUB_POWERDOWN, `SUB_PARTIAL_RESTART: begin
                code_known = 1'b1;
            end
            default: begin
                code_known = 1'b0;
            end
        endcase
    endfunction : code_known

    // Codes that are refused while the access state is locked.
    function automatic logic code_locked_out(input logic [15:0] code);
        case (code)
            `SUB_ENTER_EDIT, `SUB_POWERDOWN_ARM, `SUB_POWERDOWN,
            `SUB_PARTIAL_RESTART: begin
                code_locked_out = 1'b1;
            end
            default: begin
                code_locked_out = 1'b0;
            end
        endcase
    endfunction : code_locked_out

    ctl_state_s st_q;
    ctl_state_s st_d;
    logic       wake;
    logic       take;
    logic [15:0] code;
    logic       pin_fall;
    logic       pin_rise;
    logic       present_set;
    logic       cap_set;

    // ----------------------------------------
    // Wake detection while powered down
    // ----------------------------------------
    gauge_wake_detect #(
        .WAKE_HOLD_CYCLES (WAKE_HOLD_CYCLES)
    ) u_wake (
        .sys_clk_in            (sys_clk_in),
        .rstn_in               (rstn_in),
        .powered_down_in       (st_q.power == PWR_DOWN),
        .general_output_pin_in (general_output_pin_in),
        .wake_out              (wake)
    );

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        st_d                 = st_q;
        code                 = subcmd_in.cmd_code;
        // The host delivers each control write together with its subcommand code.
        take                 = subcmd_in.cmd_valid && (st_q.power == PWR_RUN)   // R1
                               && code_known(code)                                // R27
                               && !(core_status_in.locked_access_state
                                    && code_locked_out(code));                    // R2
        st_d.result_valid    = 1'b0;
        st_d.gauge_start     = 1'b0;
        st_d.smooth_align    = 1'b0;
        st_d.partial_restart = 1'b0;
        st_d.autocal_start   = 1'b0;
        present_set          = 1'b0;

        // Cell detect pin passes two flip-flops before any edge logic sees it.
        st_d.pin_sync = {st_q.pin_sync[0], cell_detect_pin_in};
        st_d.pin_prev = st_q.pin_sync[1];
        pin_fall      = st_q.pin_prev && !st_q.pin_sync[1];
        pin_rise      = !st_q.pin_prev && st_q.pin_sync[1];

        // Cell presence: pin edges when detection is enabled, commands otherwise.
        if (pin_detect_enable_in) begin
            if (pin_fall) begin
                st_d.cell_present = 1'b1;
                present_set       = !st_q.cell_present;
            end else if (pin_rise) begin
                st_d.cell_present = 1'b0;
            end
        end else if (take && code == `SUB_CELL_INSERTED) begin
            st_d.cell_present = 1'b1;                                             // R18
            st_d.gauge_start  = 1'b1;                                             // R18
            present_set       = !st_q.cell_present;
        end else if (take && code == `SUB_CELL_REMOVED) begin
            st_d.cell_present = 1'b0;                                             // R19
        end

        // Learned bits clear when presence sets; a capacity learn event in that cycle wins, and a resistance one only with it.
        cap_set = core_event_in.capacity_learn;
        if (cap_set) begin
            st_d.cap_learned = 1'b1;                                              // R8
        end else if (present_set) begin
            st_d.cap_learned = 1'b0;                                              // R8
        end
        if (core_event_in.resistance_learn && st_d.cap_learned) begin
            st_d.res_learned = 1'b1;                                              // R9
        end else if (present_set) begin
            st_d.res_learned = 1'b0;                                              // R9
        end

        if (core_event_in.chemistry_swap) begin
            st_d.chem_swapped = 1'b1;                                             // R12
        end else if (core_event_in.chemistry_updated) begin
            st_d.chem_swapped = 1'b0;                                             // R12
        end

        st_d.cp_model = core_status_in.constant_power_model;                     // R11

        // First autocal run is timed from initialization complete.
        if (core_status_in.init_done && st_q.autocal_armed) begin
            if (st_q.autocal_cnt >= AUTOCAL_FIRST_CYCLES - 40'h00_0000_0001) begin
                st_d.autocal_armed = 1'b0;
                st_d.autocal_run   = 1'b1;                                        // R7
                st_d.autocal_start = 1'b1;
            end else begin
                st_d.autocal_cnt = st_q.autocal_cnt + 40'h00_0000_0001;
            end
        end
        if (core_event_in.autocal_done && !st_d.autocal_start) begin
            st_d.autocal_run = 1'b0;
        end

        // Status word snapshot; reserved bits stay zero.
        st_d.status                  = 16'h0000;                                  // R27
        st_d.status[`ST_ARMED]       = st_q.armed;                                // R5
        st_d.status[`ST_WATCHDOG]    = core_status_in.watchdog_restart_seen;     // R6
        st_d.status[`ST_LOCKED]      = core_status_in.locked_access_state;       // R6
        st_d.status[`ST_CALIBRATING] = core_status_in.calibrating;               // R6
        st_d.status[`ST_AUTOCAL]     = st_q.autocal_run
                                       || core_status_in.counter_autocal_active;  // R7
        st_d.status[`ST_BOARD_CAL]   = core_status_in.board_cal_active;          // R6
        st_d.status[`ST_CAP_LEARNED] = st_q.cap_learned;                         // R8
        st_d.status[`ST_RES_LEARNED] = st_q.res_learned;                         // R9
        st_d.status[`ST_INIT_DONE]   = core_status_in.init_done;                 // R10
        st_d.status[`ST_SLEEP]       = core_status_in.sleep;                     // R10
        st_d.status[`ST_CP_MODEL]    = st_q.cp_model;                            // R11
        st_d.status[`ST_RT_FROZEN]   = core_status_in.resistance_table_frozen;   // R10
        st_d.status[`ST_VOLT_GOOD]   = core_status_in.cell_voltage_good;         // R10
        st_d.status[`ST_CHEM_SWAPPED] = st_q.chem_swapped;                       // R12

        // Subcommand execution.
        if (take) begin
            case (code)
                `SUB_STATUS: begin
                    st_d.result       = st_q.status;                              // R3 R4
                    st_d.result_valid = 1'b1;
                end
                `SUB_PART_CODE: begin
                    st_d.result       = PART_CODE;                                // R13
                    st_d.result_valid = 1'b1;
                end
                `SUB_FW_REV: begin
                    st_d.result       = FIRMWARE_REVISION;                        // R14
                    st_d.result_valid = 1'b1;
                end
                `SUB_CONFIG_CODE: begin
                    st_d.result       = {8'h00, CONFIG_CODE};                     // R15
                    st_d.result_valid = 1'b1;
                end
                `SUB_LAST_CMD: begin
                    st_d.result       = st_q.last_cmd;                            // R16
                    st_d.result_valid = 1'b1;
                end
                `SUB_CHEM_PROFILE: begin
                    st_d.result       = CHEMISTRY_PROFILE;                        // R17
                    st_d.result_valid = 1'b1;
                end
                `SUB_ENTER_EDIT: begin
                    st_d.param_edit = 1'b1;                                       // R20
                end
                `SUB_PARTIAL_RESTART: begin
                    st_d.param_edit      = 1'b0;                                  // R22
                    st_d.partial_restart = 1'b1;                                  // R22
                end
                `SUB_SMOOTH_ALIGN: begin
                    st_d.smooth_align = 1'b1;                                     // R23
                end
                `SUB_POWERDOWN_ARM: begin
                    st_d.armed = 1'b1;                                            // R5
                end
                `SUB_POWERDOWN: begin
                    if (st_q.armed) begin                                         // R25
                        st_d.power = PWR_DOWN;                                    // R24
                    end
                end
                default: begin
                end
            endcase
            // Only codes below the limit are recorded as the previous command.
            if (code != `SUB_LAST_CMD && code < `LAST_CMD_LIMIT) begin
                st_d.last_cmd = code;                                             // R16
            end
        end

        // Leaving power-down returns to normal operation, disarmed.
        case (st_q.power)
            PWR_RUN: begin
            end
            PWR_DOWN: begin
                if (wake) begin                                                   // R26
                    st_d.power = PWR_RUN;
                    st_d.armed = 1'b0;
                end
            end
            default: begin
                st_d.power = PWR_RUN;
            end
        endcase
    end

    // ----------------------------------------
    // State register
    // ----------------------------------------
    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            st_q               <= '0;
            st_q.power         <= PWR_RUN;
            st_q.result        <= `RST_RESULT;
            st_q.last_cmd      <= `RST_LAST_CMD;
            st_q.cp_model      <= `RST_CP_MODEL;                                  // R11
            st_q.status        <= 16'h0008;
            st_q.autocal_armed <= 1'b1;
        end else begin
            st_q <= st_d;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign control_result_out       = st_q.result;
    assign control_result_valid_out = st_q.result_valid;
    assign control_status_word_out  = st_q.status;
    assign cell_present_out         = st_q.cell_present;
    assign gauging_start_out        = st_q.gauge_start;
    assign param_edit_flag_out      = st_q.param_edit;
    assign partial_restart_out      = st_q.partial_restart;
    assign smoothing_align_out      = st_q.smooth_align;
    assign autocal_start_out        = st_q.autocal_start;
    assign powerdown_out            = (st_q.power == PWR_DOWN);

endmodule : gauge_control_subcommand_unit

// file: gauge_control_subcommand_props.sv
// Port checker of the gauge control subcommand unit.
`timescale 1ns/100ps
module gauge_control_subcommand_props #(
    parameter logic [15:0] PART_CODE = 16'hA5C3
) (
    // Clock and reset
    input wire logic                     sys_clk_in,
    input wire logic                     rstn_in,
    // Observed ports
    input wire gauge_pkg::subcmd_s       subcmd_in,
    input wire gauge_pkg::core_status_s  core_status_in,
    input wire logic                     pin_detect_enable_in,
    input wire logic [15:0]              control_result_out,
    input wire logic                     control_result_valid_out,
    input wire logic [15:0]              control_status_word_out,
    input wire logic                     cell_present_out,
    input wire logic                     gauging_start_out,
    input wire logic                     param_edit_flag_out,
    input wire logic                     powerdown_out
);
    import gauge_pkg::*;
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (!rstn_in);
    wire logic        go   = subcmd_in.cmd_valid && !powerdown_out;
    wire logic        free = go && !core_status_in.locked_access_state;
    wire logic [15:0] c    = subcmd_in.cmd_code;
    AST_RSVD: assert property (control_status_word_out[6:5] == 2'b00)
        else $error("reserved status bits set");
    AST_PART: assert property (go && c == 16'h0001 |=>
        control_result_valid_out && control_result_out == PART_CODE) else $error("bad part code");
    AST_LAST: assert property (go && c == 16'h0007 |=> control_result_out < 16'h0015)
        else $error("last command out of range");
    AST_ARM: assert property (free && c == 16'h001B |-> ##2 control_status_word_out[15])
        else $error("armed bit not set");
    AST_ARMFIRST: assert property ($rose(powerdown_out) |-> control_status_word_out[15])
        else $error("power-down without arming");
    AST_DOWN: assert property (free && c == 16'h001C && control_status_word_out[15]
        && !$past(powerdown_out) |=> powerdown_out) else $error("power-down not entered");
    AST_INS: assert property (go && c == 16'h000C && !pin_detect_enable_in |=>
        cell_present_out && gauging_start_out) else $error("insert not taken");
    AST_REM: assert property (go && c == 16'h000D && !pin_detect_enable_in |=>
        !cell_present_out) else $error("remove not taken");
    AST_EDIT: assert property (free && c == 16'h0013 |=> param_edit_flag_out)
        else $error("edit mode not entered");
    AST_LOCK: assert property (go && c == 16'h0013 && core_status_in.locked_access_state &&
        !param_edit_flag_out |=> !param_edit_flag_out) else $error("locked command taken");
    AST_RES: assert property ($rose(control_status_word_out[8]) |->
        control_status_word_out[9]) else $error("resistance before capacity");
    cover property (powerdown_out);
    cover property (control_result_valid_out);
    cover property ($rose(control_status_word_out[9]));
endmodule : gauge_control_subcommand_props

bind gauge_control_subcommand_unit gauge_control_subcommand_props #(.PART_CODE(PART_CODE)) chk (
    .sys_clk_in, .rstn_in, .subcmd_in, .core_status_in, .pin_detect_enable_in,
    .control_result_out, .control_result_valid_out, .control_status_word_out,
    .cell_present_out, .gauging_start_out, .param_edit_flag_out, .powerdown_out);

// file: gauge_host_model.sv
// Host model: issues control subcommands and drives the wake pin.
`timescale 1ns/100ps
module gauge_host_model (
    // Clock
    input  wire logic          sys_clk_in,
    // Toward the gauge
    output gauge_pkg::subcmd_s subcmd_out,
    output logic               general_output_pin_out
);
    import gauge_pkg::*;
    initial begin
        subcmd_out = '0;
        general_output_pin_out = 1'b0;
    end
    task automatic send(input logic [15:0] code);
        @(negedge sys_clk_in);
        subcmd_out = '{1'b1, code};
        @(negedge sys_clk_in);
        subcmd_out = '0;
    endtask : send
    task automatic wake(input int hold);
        repeat (3) @(negedge sys_clk_in);
        general_output_pin_out = 1'b1;
        repeat (hold) @(negedge sys_clk_in);
        general_output_pin_out = 1'b0;
    endtask : wake
endmodule : gauge_host_model

// file: tb_gauge_control_subcommand_unit.sv
// Testbench of the gauge control subcommand unit.
`timescale 1ns/100ps
module tb_gauge_control_subcommand_unit;
    import gauge_pkg::*;
    logic         sys_clk_in = 1'b0, rstn_in = 1'b0, pde = 1'b0, pin = 1'b1, gp;
    core_status_s cs = 10'h004;
    core_event_s  ce = '0;
    subcmd_s      sc;
    logic [15:0]  res, st, na = 16'h0000;
    logic         rv, cp, gs, ed, pr, sa, pd, ac;
    int           error_cnt = 0, n_tests = 0;
    always #2 sys_clk_in = ~sys_clk_in;
    gauge_host_model host (.sys_clk_in, .subcmd_out(sc), .general_output_pin_out(gp));
    // Part code value is arbitrary.
    gauge_control_subcommand_unit #(.PART_CODE(16'h6B2D), .CONFIG_CODE(8'h5A),
        .CHEMISTRY_PROFILE(16'h1234), .AUTOCAL_FIRST_CYCLES(40'd20), .WAKE_HOLD_CYCLES(10)) dut (
        .sys_clk_in, .rstn_in, .subcmd_in(sc), .control_result_out(res),
        .control_result_valid_out(rv), .control_status_word_out(st), .core_status_in(cs),
        .core_event_in(ce), .pin_detect_enable_in(pde), .cell_detect_pin_in(pin),
        .general_output_pin_in(gp), .cell_present_out(cp), .gauging_start_out(gs),
        .param_edit_flag_out(ed), .partial_restart_out(pr), .smoothing_align_out(sa),
        .autocal_start_out(ac), .powerdown_out(pd));
    task automatic chk(input logic [15:0] s, e);
        n_tests++;
        if (s !== e) begin
            error_cnt++;
            $display("[ERR] %0t seen %h expected %h", $time, s, e);
        end
    endtask : chk
    task automatic q(input logic [15:0] c, e);
        host.send(c);
        chk(rv, 1'b1);
        chk(res, e);
    endtask : q
    task automatic ev(input core_event_s v);
        @(negedge sys_clk_in);
        ce = v;
        @(negedge sys_clk_in);
        ce = '0;
    endtask : ev
    task automatic test_done;
        $display("checks %0d errors %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : test_done
    initial begin
        repeat (3000) @(posedge sys_clk_in);
        error_cnt++;
        test_done;
    end
    initial begin
        repeat (4) @(negedge sys_clk_in);
        rstn_in = 1'b1;
        chk(st, 16'h0008);
        q(16'h0001, 16'h6B2D);
        q(16'h0002, 16'h0100);
        q(16'h0004, 16'h005A);
        q(16'h0008, 16'h1234);
        cs = 10'h2EB;
        q(16'h0007, 16'h0008);
        q(16'h0000, 16'h5C16);
        cs = 10'h004;
        ev(5'h08); ev(5'h00); chk(st[9:8], 2'b00);
        ev(5'h10); ev(5'h08); ev(5'h00); chk(st[9:8], 2'b11);
        host.send(16'h000C); chk(cp, 1'b1); chk(gs, 1'b1);
        ev(5'h00); chk(st[9:8], 2'b00);
        host.send(16'h000D); chk(cp, 1'b0);
        pde = 1'b1;
        host.send(16'h000C); chk(cp, 1'b0);
        pin = 1'b0; repeat (3) @(negedge sys_clk_in); chk(cp, 1'b1);
        pde = 1'b0; pin = 1'b1; repeat (3) @(negedge sys_clk_in); chk(cp, 1'b1);
        ev(5'h04); ev(5'h00); chk(st[0], 1'b1);
        ev(5'h02); ev(5'h00); chk(st[0], 1'b0);
        cs = 10'h104;
        host.send(16'h0013); chk(ed, 1'b0);
        cs = 10'h004;
        host.send(16'h0013); chk(ed, 1'b1);
        host.send(16'h0042); chk(pr, 1'b1); chk(ed, 1'b0);
        host.send(16'h0019); chk(sa, 1'b1);
        host.send(16'h0003); chk(rv, 1'b0);
        q(16'h0007, 16'h0013);
        cs = 10'h014;
        repeat (30) @(negedge sys_clk_in) na += ac;
        chk(st[11], 1'b1); chk(na, 16'h0001);
        ev(5'h01); ev(5'h00); chk(st[11], 1'b0);
        host.send(16'h001C); chk(pd, 1'b0);
        host.send(16'h001B); ev(5'h00); chk(st[15], 1'b1);
        host.send(16'h001C); chk(pd, 1'b1);
        host.send(16'h0001); chk(rv, 1'b0);
        host.wake(4); ev(5'h00); chk(pd, 1'b1);
        host.wake(15); ev(5'h00); chk(pd, 1'b0); chk(st[15], 1'b0);
        test_done;
    end
endmodule : tb_gauge_control_subcommand_unit
